// file: logic/scps_top.sv
// Purpose: 3-wire serial register port with startup sequencing controls
// Assumes: Serial pins are asynchronous to ref_clk; sclk well below 20 MHz
// Notes:   Hold each sclk level for at least three ref_clk periods
// Operation
// - Power-on reset loads every register default
// - Clock and pulse outputs start disabled
// - Voltage hold bit pins tuning to mid-supply
// - Divider initialize restarts dividers, then self-clears
// - Clock and reference pulse outputs driven low while initializing
// - Request_a and calibrate bits trigger and self-clear
// - Mode bit selects counted or continuous pulses
// - Internal trigger: start bit launches pulses
// - External trigger: rising edge launches armed pulses
// - Chip select high tristates data, port ignored
// - Sample data on rising serial clock
// - Read data changes on edge per polarity
// - Command byte: direction then address, LSB first
// - Read loads addressed register and drives line
// - Burst reads return incrementing addresses
// - Write commits each completed byte, auto-increments
// - External trigger uses same pulse settings
`timescale 1ns/1ps
module scps_top (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       sclk,
    input  wire logic       chip_select_n,
    input  wire logic       serial_data_io_i,
    output logic            serial_data_io_o,
    output logic            serial_data_io_oe,
    input  wire logic       external_trigger_in,
    output logic [7:0]      clock_output,
    output logic [7:0]      reference_pulse_output,
    output logic            vco_voltage_hold,
    output logic            divider_restart,
    output logic            request_a,
    output logic            band_calibrate
);
    import scps_pkg::*;

    localparam int A_INIT_MAX = INIT_CYCLES + 2;

    logic [7:0]  mem [128];
    scps_cfg_s   cfg;
    logic [2:0]  sclk_s, cs_s, sdi_s, ext_s;
    logic [2:0]  cnt_q;
    logic        cmd_q, dir_q, oe_q, sdo_q;
    logic [6:0]  addr_q;
    logic [7:0]  rx_q, tx_q;
    logic        wr_q;
    logic [6:0]  wr_addr_q;
    logic [7:0]  wr_data_q;
    logic [7:0]  init_cnt_q;
    logic        busy_q, restart_q, request_a_q, cal_q, hold_q, clk_tog_q;
    scps_pe_e    pe_q;
    logic [7:0]  rem_q, pdiv_q;
    logic        pulse_q;
    logic [7:0]  clk_out_q, ref_out_q;

    // Synchronised pins and edges; stage 0 feeds only stage 1
    wire cs_hi    = cs_s[1];
    wire rise     = sclk_s[1] & ~sclk_s[2] & ~cs_hi;
    wire fall     = ~sclk_s[1] & sclk_s[2] & ~cs_hi;
    wire ext_rise = ext_s[1] & ~ext_s[2];
    wire sdi      = sdi_s[1];

    // Configuration view of the register space
    assign cfg.read_edge_polarity   = mem[ADDR_GEN_CTRL][BIT_RD_POL];
    assign cfg.vco_voltage_hold     = mem[ADDR_GEN_CTRL][BIT_VHOLD];
    assign cfg.pulse_trigger_source = mem[ADDR_PULSE_CTRL][BIT_TRIG_SRC];
    assign cfg.pulse_output_mode    = mem[ADDR_PULSE_CTRL][BIT_OUT_MODE];
    assign cfg.pulse_count          = mem[ADDR_PULSE_COUNT];

    // Receive byte assembly, LSB first
    wire [7:0] rx_d      = {sdi, rx_q[7:1]};
    wire       byte_done = rise & (cnt_q == 3'd7);
    wire [2:0] cnt_d     = cnt_q + 3'd1;
    wire       cmd_rd    = cmd_q & rx_d[0];
    wire       load_rd   = byte_done & (cmd_rd | (~cmd_q & dir_q));
    wire [6:0] rd_addr   = cmd_q ? rx_d[7:1] : addr_q;
    wire [7:0] tx_d      = load_rd ? mem[rd_addr] : tx_q;

    // Control decode
    wire gen_init   = mem[ADDR_GEN_CTRL][BIT_DIV_INIT];
    wire gen_request_a = mem[ADDR_GEN_CTRL][BIT_REQUEST_A];
    wire gen_cal    = mem[ADDR_GEN_CTRL][BIT_BAND_CAL];
    wire start_bit  = mem[ADDR_PULSE_START][BIT_START];
    wire init_go    = gen_init & ~busy_q;
    wire init_end   = busy_q & (init_cnt_q == 8'd1);
    wire launch     = (pe_q == SCPS_PE_ARMED)
                      & (~cfg.pulse_trigger_source | ext_rise);
    wire ptick      = (pdiv_q == 8'd0);

    // Input synchronisers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s <= 3'h7;  // Clock idles high, no false edge
            cs_s   <= 3'h7;
            sdi_s  <= 3'h0;
            ext_s  <= 3'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            cs_s   <= {cs_s[1:0], chip_select_n};
            sdi_s  <= {sdi_s[1:0], serial_data_io_i};
            ext_s  <= {ext_s[1:0], external_trigger_in};
        end
    end

    // Serial shift engine
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 3'h0;
            cmd_q <= 1'b1;
            dir_q <= 1'b0;
            oe_q  <= 1'b0;
            sdo_q <= 1'b0;
            addr_q <= 7'h00;
            rx_q  <= 8'h00;
            tx_q  <= 8'h00;
            wr_q  <= 1'b0;
            wr_addr_q <= 7'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_q <= 1'b0;
            if (cs_hi) begin
                cnt_q <= 3'h0;
                cmd_q <= 1'b1;
                dir_q <= 1'b0;
                oe_q  <= 1'b0;
            end else if (rise) begin
                cnt_q <= cnt_d;
                rx_q  <= rx_d;
                tx_q  <= tx_d;
                if (cfg.read_edge_polarity)
                    sdo_q <= tx_d[cnt_d];
                if (byte_done && cmd_q) begin
                    cmd_q  <= 1'b0;
                    dir_q  <= rx_d[0];
                    addr_q <= rx_d[7:1] + {6'h00, rx_d[0]};
                    oe_q   <= rx_d[0];
                end else if (byte_done) begin
                    addr_q <= addr_q + 7'h01;
                    wr_q   <= ~dir_q;
                    wr_addr_q <= addr_q;
                    wr_data_q <= rx_d;
                end
            end else if (fall && !cfg.read_edge_polarity) begin
                sdo_q <= tx_q[cnt_q];
            end
        end
    end

    // Register space; a host write wins over a self-clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 128; i++)
                mem[i] <= scps_reg_default(i);
        end else begin
            if (init_end)
                mem[ADDR_GEN_CTRL][BIT_DIV_INIT] <= 1'b0;
            if (gen_request_a)
                mem[ADDR_GEN_CTRL][BIT_REQUEST_A] <= 1'b0;
            if (gen_cal)
                mem[ADDR_GEN_CTRL][BIT_BAND_CAL] <= 1'b0;
            if (launch)
                mem[ADDR_PULSE_START][BIT_START] <= 1'b0;
            if (wr_q)
                mem[wr_addr_q] <= wr_data_q;
        end
    end

    // Divider restart, request_a and calibration launch
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt_q <= 8'h00;
            busy_q     <= 1'b0;
            restart_q  <= 1'b0;
            request_a_q   <= 1'b0;
            cal_q      <= 1'b0;
            hold_q     <= 1'b1;
        end else begin
            restart_q <= init_go;
            request_a_q  <= gen_request_a;
            cal_q     <= gen_cal;
            hold_q    <= cfg.vco_voltage_hold;
            if (init_go) begin
                busy_q     <= 1'b1;
                init_cnt_q <= 8'(INIT_CYCLES);
            end else if (busy_q) begin
                init_cnt_q <= init_cnt_q - 8'd1;
                busy_q     <= ~init_end;
            end
        end
    end

    // Reference pulse engine, internal or external trigger
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pe_q    <= SCPS_PE_IDLE;
            rem_q   <= 8'h00;
            pdiv_q  <= 8'h00;
            pulse_q <= 1'b0;
        end else if (busy_q) begin
            pe_q    <= SCPS_PE_IDLE;
            pulse_q <= 1'b0;
            pdiv_q  <= 8'h00;
        end else begin
            pdiv_q <= ptick ? 8'(PULSE_HALF_CY - 1) : pdiv_q - 8'd1;
            case (pe_q)
                SCPS_PE_IDLE: begin
                    if (start_bit)
                        pe_q <= SCPS_PE_ARMED;
                end
                SCPS_PE_ARMED: begin
                    if (launch) begin
                        pe_q  <= SCPS_PE_RUN;
                        rem_q <= cfg.pulse_count;
                    end
                end
                SCPS_PE_RUN: begin
                    if (!pulse_q && !cfg.pulse_output_mode
                        && rem_q == 8'd0)
                        pe_q <= SCPS_PE_IDLE;
                    else if (ptick && pulse_q) begin
                        pulse_q <= 1'b0;
                        if (!cfg.pulse_output_mode)
                            rem_q <= rem_q - 8'd1;
                    end else if (ptick)
                        pulse_q <= 1'b1;
                end
                default: pe_q <= SCPS_PE_IDLE;
            endcase
        end
    end

    // Output stages, low during restart and until enabled
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_tog_q <= 1'b0;
            clk_out_q <= 8'h00;
            ref_out_q <= 8'h00;
        end else begin
            clk_tog_q <= ~clk_tog_q & ~busy_q;
            clk_out_q <= busy_q ? 8'h00
                                : {8{clk_tog_q}} & mem[ADDR_CLK_OE];
            ref_out_q <= busy_q ? 8'h00
                                : {8{pulse_q}} & mem[ADDR_REF_OE];
        end
    end

    assign serial_data_io_o       = sdo_q;
    assign serial_data_io_oe      = oe_q;
    assign clock_output           = clk_out_q;
    assign reference_pulse_output = ref_out_q;
    assign vco_voltage_hold       = hold_q;
    assign divider_restart        = restart_q;
    assign request_a              = request_a_q;
    assign band_calibrate         = cal_q;

    a_cs_tristate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        cs_hi |=> !serial_data_io_oe)
        else $error("data line driven while deselected");

    a_init_outlow: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        busy_q |=> clock_output == 8'h00 && reference_pulse_output == 8'h00)
        else $error("outputs active during divider restart");

    a_init_selfclr: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        init_go |=> busy_q ##[1:A_INIT_MAX] !busy_q)
        else $error("divider restart did not finish");

    a_request_a_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        gen_request_a && !wr_q |=> !gen_request_a && request_a ##1 !request_a)
        else $error("request_a bit did not self-clear");

    a_hold_follows: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !wr_q ##1 !wr_q |-> vco_voltage_hold == cfg.vco_voltage_hold)
        else $error("voltage hold output does not follow bit");

    a_write_commit: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_q && wr_addr_q == ADDR_CLK_OE
        |=> mem[ADDR_CLK_OE] == $past(wr_data_q))
        else $error("write byte not committed");

    a_read_turn: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        byte_done && cmd_rd |=> serial_data_io_oe && tx_q == $past(tx_d))
        else $error("read did not turn the line");

    a_int_launch: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        pe_q == SCPS_PE_ARMED && !cfg.pulse_trigger_source && !busy_q
        && !wr_q |=> pe_q == SCPS_PE_RUN && !start_bit)
        else $error("internal trigger did not launch");

    a_ext_wait: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        pe_q == SCPS_PE_ARMED && cfg.pulse_trigger_source && !ext_rise
        && !busy_q |=> pe_q == SCPS_PE_ARMED)
        else $error("external trigger launched without edge");
endmodule : scps_top

// file: logic/scps_pkg.sv
// Purpose: Constants and types for the serial configuration port sequencer
// Assumes: 40 MHz ref_clk, 8-bit registers in a 128-entry space
// Notes:   Control bits live inside the register space
package scps_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int INIT_TIME_NS  = 400;   // Divider restart hold time
    localparam int PULSE_HALF_NS = 400;   // Half period of a reference pulse
    localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int PULSE_HALF_CY = (PULSE_HALF_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    localparam logic [6:0] ADDR_PULSE_COUNT = 7'h1A;
    localparam logic [6:0] ADDR_PULSE_CTRL  = 7'h1C;
    localparam logic [6:0] ADDR_PULSE_START = 7'h70;
    localparam logic [6:0] ADDR_GEN_CTRL    = 7'h71;
    localparam logic [6:0] ADDR_CLK_OE      = 7'h74;
    localparam logic [6:0] ADDR_REF_OE      = 7'h76;

    localparam int BIT_RD_POL   = 0;  // General control fields
    localparam int BIT_DIV_INIT = 1;
    localparam int BIT_REQUEST_A   = 2;
    localparam int BIT_BAND_CAL = 3;
    localparam int BIT_VHOLD    = 4;
    localparam int BIT_TRIG_SRC = 0;  // Pulse control fields
    localparam int BIT_OUT_MODE = 1;
    localparam int BIT_START    = 0;  // Pulse start field

    localparam logic [7:0] GEN_CTRL_RST = 8'h10;  // Voltage hold set
    localparam logic [7:0] REG_RST      = 8'h00;

    typedef enum logic [2:0] {
        SCPS_PE_IDLE  = 3'b001,
        SCPS_PE_ARMED = 3'b010,
        SCPS_PE_RUN   = 3'b100
    } scps_pe_e;

    typedef struct packed {
        logic       read_edge_polarity;
        logic       vco_voltage_hold;
        logic       pulse_trigger_source;
        logic       pulse_output_mode;
        logic [7:0] pulse_count;
    } scps_cfg_s;

    // Power-on value of one register
    function automatic logic [7:0] scps_reg_default(input int idx);
        scps_reg_default = (idx == int'(ADDR_GEN_CTRL)) ? GEN_CTRL_RST
                                                         : REG_RST;
    endfunction : scps_reg_default
endpackage : scps_pkg

// file: verification/scps_spi_master.sv
// Purpose: Serial master model that drives the 3-wire configuration port
// Assumes: Clock half period of 6 ref_clk cycles, clock idles high
// Notes:   Tasks are called by the bench; data changes only while clock low
`timescale 1ns/1ps
module scps_spi_master (
    input  wire logic ref_clk,
    input  wire logic line,
    output logic      sclk,
    output logic      chip_select_n,
    output logic      drv_en,
    output logic      drv_val
);
    localparam int HALF = 6;

    // Idle state: deselected, clock still, line released
    initial begin
        sclk = 1'b1;
        chip_select_n = 1'b1;
        drv_en = 1'b0;
        drv_val = 1'b0;
    end

    // Select the device and give the synchronisers time
    task automatic begin_xfer();
        @(negedge ref_clk);
        chip_select_n = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : begin_xfer

    // Release select after a half period, whole bytes or not
    task automatic end_xfer();
        repeat (HALF) @(negedge ref_clk);
        chip_select_n = 1'b1;
        drv_en = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask : end_xfer

    // Shift nb bits LSB first; sample the line just before each rise
    task automatic shift(input logic [7:0] tx, input int nb,
                         input logic drive, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nb; i++) begin
            @(negedge ref_clk);
            sclk = 1'b0;
            drv_en = drive;
            drv_val = tx[i];
            repeat (HALF) @(negedge ref_clk);
            rx[i] = line;
            sclk = 1'b1;
            repeat (HALF - 1) @(negedge ref_clk);
        end
    endtask : shift
endmodule : scps_spi_master

// file: verification/scps_top_tb.sv
// Purpose: Self-checking bench for the serial port sequencer
// Assumes: 40 MHz ref_clk, fixed seed, partner master model
// Notes:   Expectations come from a shadow memory and constants
`timescale 1ns/1ps
module scps_top_tb;
    import scps_pkg::*;
    logic ref_clk, rst_b, io_i, io_o, io_oe, last_io, ext_trig;
    logic m_en, m_val, sclk, cs_n, div_p, rl_p, cal_p, vhold;
    logic [7:0] clk_out, ref_out, mem [128];
    logic seen_div, seen_rl, seen_bc, init_bad;
    int err_total, check_count, pcnt, win, seed;

    // Line level: device drive, master drive, else a toggling pattern
    assign io_i = io_oe ? io_o : (m_en ? m_val : ~last_io);

    scps_top i_scps_top (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
        .chip_select_n(cs_n), .serial_data_io_i(io_i),
        .serial_data_io_o(io_o), .serial_data_io_oe(io_oe),
        .external_trigger_in(ext_trig), .clock_output(clk_out),
        .reference_pulse_output(ref_out), .vco_voltage_hold(vhold),
        .divider_restart(div_p), .request_a(rl_p), .band_calibrate(cal_p));

    scps_spi_master i_scps_spi_master (.ref_clk(ref_clk), .line(io_i),
        .sclk(sclk), .chip_select_n(cs_n), .drv_en(m_en), .drv_val(m_val));

    // Clock generation
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Monitors: pulse edges, control pulses, outputs during init
    always @(posedge ref_clk) begin
        last_io <= io_i;
        if (div_p) begin
            seen_div = 1'b1;
            win = 14;
        end else if (win > 0) win = win - 1;
        if (win > 0 && win <= 12 && (clk_out !== 8'h00 || ref_out !== 8'h00))
            init_bad = 1'b1;
        if (rl_p) seen_rl = 1'b1;
        if (cal_p) seen_bc = 1'b1;
    end
    always @(posedge ref_out[0]) pcnt = pcnt + 1;

    task automatic chk(input string nm, input logic [7:0] exp, seen);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rx;
        i_scps_spi_master.begin_xfer();
        i_scps_spi_master.shift({a, 1'b0}, 8, 1'b1, rx);
        i_scps_spi_master.shift(d, 8, 1'b1, rx);
        i_scps_spi_master.end_xfer();
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] rx;
        i_scps_spi_master.begin_xfer();
        i_scps_spi_master.shift({a, 1'b1}, 8, 1'b1, rx);
        i_scps_spi_master.shift(8'h00, 8, 1'b0, rx);
        i_scps_spi_master.end_xfer();
        chk("read", exp, rx);
    endtask : rd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Watchdog against a hung run
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        $display("mismatch watchdog expected end seen hang");
        tally_and_finish();
    end

    initial begin
        logic [7:0] rx, d, c0;
        logic [6:0] a;
        {rst_b, ext_trig, last_io, seen_div, seen_rl, seen_bc} = '0;
        {init_bad, err_total, check_count, pcnt, win} = '0;
        seed = 32'h7FEC7CF2;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("hold_rst", 8'h01, {7'h00, vhold});
        chk("clk_rst", 8'h00, clk_out);
        chk("ref_rst", 8'h00, ref_out);
        rd(ADDR_GEN_CTRL, GEN_CTRL_RST);
        rd(ADDR_CLK_OE, 8'h00);
        rd(ADDR_REF_OE, 8'h00);
        chk("oe_idle", 8'h00, {7'h00, io_oe});
        // Aborted 3-bit transfer must not disturb the next one
        i_scps_spi_master.begin_xfer();
        i_scps_spi_master.shift(8'h05, 3, 1'b1, rx);
        i_scps_spi_master.end_xfer();
        $display("test reset done");
        // Random bursts written then read back, both read polarities
        for (int pol = 0; pol < 2; pol++) begin
            wr(ADDR_GEN_CTRL, 8'h10 | 8'(pol));
            for (int it = 0; it < 3; it++) begin
                a = 7'($unsigned($random(seed)) % 96);
                i_scps_spi_master.begin_xfer();
                i_scps_spi_master.shift({a, 1'b0}, 8, 1'b1, rx);
                for (int k = 0; k < 3; k++) begin
                    d = 8'($random(seed));
                    mem[a + 7'(k)] = d;
                    i_scps_spi_master.shift(d, 8, 1'b1, rx);
                end
                i_scps_spi_master.end_xfer();
                i_scps_spi_master.begin_xfer();
                i_scps_spi_master.shift({a, 1'b1}, 8, 1'b1, rx);
                for (int k = 0; k < 3; k++) begin
                    i_scps_spi_master.shift(8'h00, 8, 1'b0, rx);
                    chk("burst", mem[a + 7'(k)], rx);
                end
                i_scps_spi_master.end_xfer();
                chk("oe_off", 8'h00, {7'h00, io_oe});
            end
        end
        $display("test bursts done");
        // Enable clocks, then restart dividers
        wr(ADDR_CLK_OE, 8'hFF);
        wr(ADDR_REF_OE, 8'hFF);
        @(negedge ref_clk);
        c0 = clk_out;
        @(negedge ref_clk);
        chk("clk_toggle", ~c0, clk_out);
        wr(ADDR_GEN_CTRL, 8'h12);
        chk("div_pulse", 8'h01, {7'h00, seen_div});
        repeat (20) @(negedge ref_clk);
        chk("init_low", 8'h00, {7'h00, init_bad});
        rd(ADDR_GEN_CTRL, 8'h10);
        wr(ADDR_GEN_CTRL, 8'h1C);
        chk("request_a", 8'h01, {7'h00, seen_rl});
        chk("cal", 8'h01, {7'h00, seen_bc});
        rd(ADDR_GEN_CTRL, 8'h10);
        wr(ADDR_GEN_CTRL, 8'h00);
        chk("hold_off", 8'h00, {7'h00, vhold});
        $display("test controls done");
        // Counted internal sequences, restarted each time
        wr(ADDR_PULSE_CTRL, 8'h00);
        for (int c = 1; c < 3; c++) begin
            wr(ADDR_PULSE_COUNT, 8'(c));
            pcnt = 0;
            wr(ADDR_PULSE_START, 8'h01);
            repeat (200) @(negedge ref_clk);
            chk("counted", 8'(c), pcnt[7:0]);
            rd(ADDR_PULSE_START, 8'h00);
        end
        // External trigger releases the armed sequence
        wr(ADDR_PULSE_CTRL, 8'h01);
        wr(ADDR_PULSE_COUNT, 8'h03);
        pcnt = 0;
        wr(ADDR_PULSE_START, 8'h01);
        repeat (100) @(negedge ref_clk);
        chk("armed", 8'h00, pcnt[7:0]);
        ext_trig = 1'b1;
        repeat (8) @(negedge ref_clk);
        ext_trig = 1'b0;
        repeat (200) @(negedge ref_clk);
        chk("ext", 8'h03, pcnt[7:0]);
        // Continuous mode keeps pulsing
        wr(ADDR_PULSE_CTRL, 8'h02);
        pcnt = 0;
        wr(ADDR_PULSE_START, 8'h01);
        repeat (400) @(negedge ref_clk);
        chk("cont", 8'h01, {7'h00, pcnt > 5});
        // Restart during continuous pulses: outputs low, engine stops
        wr(ADDR_GEN_CTRL, 8'h02);
        pcnt = 0;
        repeat (100) @(negedge ref_clk);
        chk("init_ref", 8'h00, {7'h00, init_bad});
        chk("init_stop", 8'h00, pcnt[7:0]);
        $display("test pulses done");
        tally_and_finish();
    end
endmodule : scps_top_tb
